// [src/cwu_pkg.sv]
// Purpose: Shared constants and types for the complementary waveform unit timing block.
// Assumes: 100 MHz generator clock, 32-bit Avalon-MM register slave.
// Notes:   Offsets are byte addresses; every register takes one aligned word.
package cwu_pkg;

  // ==========================================================================
  // Widths and clock
  // ==========================================================================
  localparam int CNT_W         = 6;   // Width of every timing count field
  localparam int CLK_PERIOD_NS = 10;  // Generator clock period

  // ==========================================================================
  // Register offsets (byte addresses)
  // ==========================================================================
  localparam logic [4:0] RISING_DEADBAND_OFS  = 5'h00;
  localparam logic [4:0] FALLING_DEADBAND_OFS = 5'h04;
  localparam logic [4:0] RISING_BLANKING_OFS  = 5'h08;
  localparam logic [4:0] FALLING_BLANKING_OFS = 5'h0c;
  localparam logic [4:0] RISING_PHASE_OFS     = 5'h10;
  localparam logic [4:0] FALLING_PHASE_OFS    = 5'h14;
  localparam logic [4:0] TIMING_CONTROL_OFS   = 5'h18;
  localparam logic [4:0] TIMING_STATUS_OFS    = 5'h1c;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int CTRL_ENABLE_BIT = 0;  // Unit enable
  localparam int CTRL_FDBS_BIT   = 6;  // falling_deadband_source_sel
  localparam int CTRL_RDBS_BIT   = 7;  // rising_deadband_source_sel
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int STAT_PRI_BIT    = 0;  // Primary output level
  localparam int STAT_CMP_BIT    = 1;  // Complementary output level
  localparam int STAT_RBLK_BIT   = 2;  // Rising blanking window open
  localparam int STAT_FBLK_BIT   = 3;  // Falling blanking window open

  // ==========================================================================
  // Delay-chain element timing
  // ==========================================================================
  localparam int CHAIN_ELEM_NS   = 20;  // One delay-chain element period
  localparam int CHAIN_ELEM_CLKS = (CHAIN_ELEM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHAIN_W         = 4;   // Width of the element divider

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [CNT_W-1:0] rising_deadband_value;
    logic [CNT_W-1:0] falling_deadband_value;
    logic [CNT_W-1:0] rising_blank_value;
    logic [CNT_W-1:0] falling_blank_value;
    logic [CNT_W-1:0] rising_phase_value;
    logic [CNT_W-1:0] falling_phase_value;
  } timing_cfg_t;

endpackage

// [src/cwu_timing.sv]
// Purpose: Dead-band, blanking and phase timing of the complementary waveform unit.
// Assumes: Rising and falling event levels come from asynchronous event-select logic.
// Notes:   Count registers are not reset; they power up unknown and keep their value.
//
// Notes on behaviour
// - Chain source: complementary delay in chain elements.
// - Clock source: complementary delay in clock periods.
// - Rising blank count masks following falling events.
// - Falling blank count masks following rising events.
// - Rising phase count postpones the rising event.
// - Falling phase count postpones the falling event.
// - Upper two count bits read as zero.
// - Count fields are unreset and keep contents.
// - Rising dead-band delays primary, source selectable.
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module cwu_timing
  import cwu_pkg::*;
(
  input  wire logic        ref_clk_in,        // Generator clock, 100 MHz
  input  wire logic        reset_in,          // Synchronous reset, active high
  input  wire logic [4:0]  address_in,        // Avalon byte address
  input  wire logic        read_in,           // Avalon read strobe
  input  wire logic        write_in,          // Avalon write strobe
  input  wire logic [3:0]  byteenable_in,     // Avalon byte enables
  input  wire logic [31:0] writedata_in,      // Avalon write data
  output logic [31:0]      readdata_out,      // Avalon read data
  output logic             waitrequest_out,   // Avalon wait request
  input  wire logic        rise_event_in,     // Rising event level, asynchronous
  input  wire logic        fall_event_in,     // Falling event level, asynchronous
  output logic             primary_out,       // Primary waveform
  output logic             complementary_out  // Complementary waveform
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  timing_cfg_t        cfg_reg;          // Six timing counts, never reset
  logic [7:0]         ctrl_reg;         // Enable and source selects
  logic               ack_reg;          // Bus answer phase
  logic               rise_sync;        // Synchronised rising event level
  logic               fall_sync;        // Synchronised falling event level
  logic               rise_prev_reg;    // Previous rising level for edge detect
  logic               fall_prev_reg;    // Previous falling level for edge detect
  logic               rise_edge;        // Rising event input seen
  logic               fall_edge;        // Falling event input seen
  logic               rise_ok;          // Rising input not blanked
  logic               fall_ok;          // Falling input not blanked
  logic               rise_ph_done;     // Rising phase delay expired
  logic               fall_ph_done;     // Falling phase delay expired
  logic               rise_act;         // Rising event takes effect
  logic               fall_act;         // Falling event takes effect
  logic               rblk_busy;        // Rising blanking window open
  logic               fblk_busy;        // Falling blanking window open
  logic               rdb_done;         // Rising dead-band expired
  logic               fdb_done;         // Falling dead-band expired
  logic               rdb_busy;         // Rising dead-band running
  logic               fdb_busy;         // Falling dead-band running
  logic               enable;           // Unit enabled
  logic               off;              // Unit disabled, abort all timing
  logic [CHAIN_W-1:0] chain_cnt_reg;    // Delay-chain element divider
  logic               chain_tick_reg;   // One delay-chain element elapsed
  logic               rdb_step;         // Time base of rising dead-band
  logic               fdb_step;         // Time base of falling dead-band
  logic               bus_wr;           // Write takes effect this edge
  logic [7:0]         rd_byte;          // Selected read value
  logic [7:0]         status;           // Live status byte

  assign enable = ctrl_reg[CTRL_ENABLE_BIT];
  assign off    = ~enable;

  // ==========================================================================
  // Avalon slave: one wait cycle, then the answer
  // ==========================================================================
  // Waitrequest stays high while idle so a new request always waits one cycle.
  assign waitrequest_out = ~ack_reg;
  assign bus_wr          = write_in & ack_reg & byteenable_in[0];

  // Answer phase toggles so back-to-back requests each see one wait cycle
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read_in | write_in) & ~ack_reg;
    end
  end

  // Timing counts: no reset term, so they keep contents across resets
  always_ff @(posedge ref_clk_in) begin
    if (bus_wr) begin
      unique case (address_in)
        RISING_DEADBAND_OFS:  cfg_reg.rising_deadband_value  <= writedata_in[CNT_W-1:0];
        FALLING_DEADBAND_OFS: cfg_reg.falling_deadband_value <= writedata_in[CNT_W-1:0];
        RISING_BLANKING_OFS:  cfg_reg.rising_blank_value     <= writedata_in[CNT_W-1:0];
        FALLING_BLANKING_OFS: cfg_reg.falling_blank_value    <= writedata_in[CNT_W-1:0];
        RISING_PHASE_OFS:     cfg_reg.rising_phase_value     <= writedata_in[CNT_W-1:0];
        FALLING_PHASE_OFS:    cfg_reg.falling_phase_value    <= writedata_in[CNT_W-1:0];
        default: ;                                       // Other addresses hold
      endcase
    end
  end

  // Control register: enable and dead-band source selects
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ctrl_reg <= CTRL_RESET;
    end else if (bus_wr && address_in == TIMING_CONTROL_OFS) begin
      ctrl_reg <= writedata_in[7:0];
    end
  end

  // Live status bits
  always_comb begin
    status                = 8'h00;
    status[STAT_PRI_BIT]  = primary_out;
    status[STAT_CMP_BIT]  = complementary_out;
    status[STAT_RBLK_BIT] = rblk_busy;
    status[STAT_FBLK_BIT] = fblk_busy;
  end

  // Read mux: count fields sit in bits 5:0, the two bits above read zero
  always_comb begin
    unique case (address_in)
      RISING_DEADBAND_OFS:  rd_byte = {2'b00, cfg_reg.rising_deadband_value};
      FALLING_DEADBAND_OFS: rd_byte = {2'b00, cfg_reg.falling_deadband_value};
      RISING_BLANKING_OFS:  rd_byte = {2'b00, cfg_reg.rising_blank_value};
      FALLING_BLANKING_OFS: rd_byte = {2'b00, cfg_reg.falling_blank_value};
      RISING_PHASE_OFS:     rd_byte = {2'b00, cfg_reg.rising_phase_value};
      FALLING_PHASE_OFS:    rd_byte = {2'b00, cfg_reg.falling_phase_value};
      TIMING_CONTROL_OFS:   rd_byte = ctrl_reg;
      TIMING_STATUS_OFS:    rd_byte = status;
      default:              rd_byte = 8'h00;   // Unaligned address reads zero
    endcase
  end

  // Read data registered on the edge that opens the answer phase
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      readdata_out <= 32'h0000_0000;
    end else if (read_in && !ack_reg) begin
      readdata_out <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================================
  // Event inputs: synchronise, then detect the active edge
  // ==========================================================================
  level_sync rise_sync_u (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   (rise_event_in),
    .sync_out   (rise_sync)
  );

  level_sync fall_sync_u (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   (fall_event_in),
    .sync_out   (fall_sync)
  );

  // Edge memory for both event lines
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rise_prev_reg <= 1'b0;
      fall_prev_reg <= 1'b0;
    end else begin
      rise_prev_reg <= rise_sync;
      fall_prev_reg <= fall_sync;
    end
  end

  assign rise_edge = rise_sync & ~rise_prev_reg;
  assign fall_edge = fall_sync & ~fall_prev_reg;

  // Blanking: an input arriving inside the opposite window is dropped, not queued
  assign rise_ok = rise_edge & enable & ~fblk_busy;
  assign fall_ok = fall_edge & enable & ~rblk_busy;

  // ==========================================================================
  // Phase delays
  // ==========================================================================
  delay_counter rise_phase_u (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .start_in   (rise_ok),
    .abort_in   (off),
    .step_in    (1'b1),
    .load_in    (cfg_reg.rising_phase_value),
    .busy_out   (),
    .done_out   (rise_ph_done)
  );

  delay_counter fall_phase_u (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .start_in   (fall_ok),
    .abort_in   (off),
    .step_in    (1'b1),
    .load_in    (cfg_reg.falling_phase_value),
    .busy_out   (),
    .done_out   (fall_ph_done)
  );

  // Coincident events: falling wins so the primary never stays on by accident
  assign fall_act = fall_ph_done & enable;
  assign rise_act = rise_ph_done & enable & ~fall_ph_done;

  // ==========================================================================
  // Blanking windows open when an event takes effect
  // ==========================================================================
  delay_counter rise_blank_u (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .start_in   (rise_act),
    .abort_in   (off),
    .step_in    (1'b1),
    .load_in    (cfg_reg.rising_blank_value),
    .busy_out   (rblk_busy),
    .done_out   ()
  );

  delay_counter fall_blank_u (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .start_in   (fall_act),
    .abort_in   (off),
    .step_in    (1'b1),
    .load_in    (cfg_reg.falling_blank_value),
    .busy_out   (fblk_busy),
    .done_out   ()
  );

  // ==========================================================================
  // Delay-chain time base
  // ==========================================================================
  // The analog chain is modelled as a tick every element period of clocks.
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      chain_cnt_reg  <= '0;
      chain_tick_reg <= 1'b0;
    end else if (chain_cnt_reg == CHAIN_W'(CHAIN_ELEM_CLKS - 1)) begin
      chain_cnt_reg  <= '0;
      chain_tick_reg <= 1'b1;
    end else begin
      chain_cnt_reg  <= chain_cnt_reg + 1'b1;
      chain_tick_reg <= 1'b0;
    end
  end

  assign rdb_step = ctrl_reg[CTRL_RDBS_BIT] ? chain_tick_reg : 1'b1;
  assign fdb_step = ctrl_reg[CTRL_FDBS_BIT] ? chain_tick_reg : 1'b1;

  // ==========================================================================
  // Dead-band counters; the opposite event cancels a pending turn-on
  // ==========================================================================
  delay_counter rise_db_u (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .start_in   (rise_act),
    .abort_in   (off | fall_act),
    .step_in    (rdb_step),
    .load_in    (cfg_reg.rising_deadband_value),
    .busy_out   (rdb_busy),
    .done_out   (rdb_done)
  );

  delay_counter fall_db_u (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .start_in   (fall_act),
    .abort_in   (off | rise_act),
    .step_in    (fdb_step),
    .load_in    (cfg_reg.falling_deadband_value),
    .busy_out   (fdb_busy),
    .done_out   (fdb_done)
  );

  // ==========================================================================
  // Output waveforms
  // ==========================================================================
  // Primary: off at once on a falling event, on after rising dead-band
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      primary_out <= 1'b0;
    end else if (off || fall_act) begin
      primary_out <= 1'b0;
    end else if (rdb_done && !fdb_busy) begin
      primary_out <= 1'b1;
    end
  end

  // Complementary: off at once on a rising event, on after falling dead-band
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      complementary_out <= 1'b0;
    end else if (off || rise_act) begin
      complementary_out <= 1'b0;
    end else if (fdb_done && !rdb_busy) begin
      complementary_out <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence rise_take_s;
    rise_ok && cfg_reg.rising_phase_value == 6'h00;
  endsequence

  sequence rise_effect_s;
    rise_ph_done ##1 !complementary_out;
  endsequence

  zero_phase_rise_a: assert property (
    rise_take_s |=> rise_ph_done)
    else $error("rising event with zero phase did not act next clock");
  comp_drop_rise_a: assert property (
    rise_take_s |=> rise_effect_s)
    else $error("complementary not dropped after rising event");
  rise_blank_a: assert property (
    rise_act && cfg_reg.rising_blank_value != 6'h00 |=> rblk_busy)
    else $error("rising blanking window did not open");
  fall_blank_a: assert property (
    fall_act && cfg_reg.falling_blank_value != 6'h00 |=> fblk_busy)
    else $error("falling blanking window did not open");
  pri_drop_a: assert property (
    fall_act |=> !primary_out)
    else $error("primary not dropped after falling event");
  no_overlap_a: assert property (
    !(primary_out && complementary_out))
    else $error("both outputs high together");
  upper_zero_a: assert property (
    read_in && !ack_reg && address_in < TIMING_CONTROL_OFS |=> readdata_out[7:6] == 2'b00)
    else $error("unimplemented count bits read nonzero");
  clock_db_a: assert property (
    fall_act && !ctrl_reg[CTRL_FDBS_BIT] && cfg_reg.falling_deadband_value == 6'h04
      ##1 !rise_act [*4] |=> fdb_done)
    else $error("falling dead-band of four clocks missed");

endmodule

// [src/delay_counter.sv]
// Purpose: Restartable down-counter used for dead-band, blanking and phase delays.
// Assumes: step_in marks one period of the selected time base.
// Notes:   A zero load gives done on the next clock and no busy time.
`timescale 1ns/1ps
module delay_counter
  import cwu_pkg::*;
(
  input  wire logic             ref_clk_in,  // Generator clock
  input  wire logic             reset_in,    // Synchronous reset, active high
  input  wire logic             start_in,    // Qualifying event, restarts the count
  input  wire logic             abort_in,    // Cancel a running count
  input  wire logic             step_in,     // One period of the time base
  input  wire logic [CNT_W-1:0] load_in,     // Programmed count
  output logic                  busy_out,    // Count running
  output logic                  done_out     // One-cycle pulse at expiry
);

  logic [CNT_W-1:0] cnt_reg;  // Periods still to run

  // ==========================================================================
  // Count process
  // ==========================================================================
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt_reg  <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_reg  <= load_in;
        busy_out <= (load_in != '0);
        done_out <= (load_in == '0);
      end else if (abort_in) begin
        busy_out <= 1'b0;                     // Cancelled: no expiry pulse
      end else if (busy_out && step_in) begin
        cnt_reg <= cnt_reg - 1'b1;
        if (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  zero_load_done_a: assert property (
    start_in && load_in == '0 |=> done_out && !busy_out)
    else $error("zero count did not expire on the next clock");
  last_step_done_a: assert property (
    busy_out && step_in && cnt_reg == 6'h01 && !start_in && !abort_in |=> done_out && !busy_out)
    else $error("counter missed its expiry");

endmodule

// [src/level_sync.sv]
// Purpose: Two-flop synchroniser for an event level from outside the clock domain.
// Assumes: Input is a slow level or a pulse of at least two clocks.
// Notes:   The first flop feeds only the second one.
`timescale 1ns/1ps
module level_sync (
  input  wire logic ref_clk_in,  // Generator clock
  input  wire logic reset_in,    // Synchronous reset, active high
  input  wire logic async_in,    // Level from another domain
  output logic      sync_out     // Synchronised level
);

  logic meta_reg;  // First stage, read by the second stage only

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [verif/cwu_timing_tb.sv]
// Purpose: Self-checking bench for the timing block over its register bus.
// Assumes: Bus waits are polled, not counted; event edges spaced well apart.
// Notes:   Edge counts start at the edge that raises the event pin.
`timescale 1ns/1ps
module cwu_timing_tb;
  import cwu_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        ref_clk_in = 1'b0;     // Generator clock
  logic        reset_in = 1'b1;       // Synchronous reset
  logic        read_in = 1'b0;        // Bus read
  logic        write_in = 1'b0;       // Bus write
  logic [4:0]  address_in = 5'h00;    // Bus address
  logic [31:0] writedata_in = 32'h0;  // Bus write data
  logic [31:0] readdata_out;          // Bus read data
  logic        waitrequest_out;       // Bus wait
  logic        rise_event_in = 1'b0;  // Rising event pin
  logic        fall_event_in = 1'b0;  // Falling event pin
  logic        primary_out;           // Primary waveform
  logic        complementary_out;     // Complementary waveform
  logic        overlap;               // Shoot-through seen
  logic [31:0] q;                     // Last read data
  int          errors = 0;            // Mismatch count
  int          n_tests = 0;           // Comparison count
  int          n_on;                  // Edges to turn-on
  int          n_off;                 // Edges to turn-off

  always #5 ref_clk_in = ~ref_clk_in;

  cwu_timing cwu_timing_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .byteenable_in(4'h1), .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .rise_event_in(rise_event_in),
    .fall_event_in(fall_event_in), .primary_out(primary_out),
    .complementary_out(complementary_out));
  power_stage_model power_stage_model_i (.ref_clk_in(ref_clk_in), .high_in(primary_out),
    .low_in(complementary_out), .overlap_out(overlap));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One bus access; request holds until an edge samples waitrequest low
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    write_in <= wr;
    read_in <= !wr;
    address_in <= a;
    writedata_in <= {24'h0, d};
    do @(posedge ref_clk_in); while (waitrequest_out !== 1'b0);
    q = readdata_out;
    write_in <= 1'b0;
    read_in <= 1'b0;
  endtask
  task rst;
    @(posedge ref_clk_in) reset_in <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    reset_in <= 1'b0;
  endtask
  // Raise an event pin, count edges until each output moves
  task ev(input bit rise);
    n_on = -1;
    n_off = -1;
    @(posedge ref_clk_in);
    if (rise) rise_event_in <= 1'b1;
    else fall_event_in <= 1'b1;
    for (int n = 0; n < 80 && n_on < 0; n++) begin
      @(negedge ref_clk_in);
      if (n_off < 0 && (rise ? complementary_out : primary_out) === 1'b0) n_off = n;
      if ((rise ? primary_out : complementary_out) === 1'b1) n_on = n;
    end
    @(posedge ref_clk_in);
    rise_event_in <= 1'b0;
    fall_event_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask
  // Event inside a blank window: primary must not move
  task hold(input bit rise, input logic lvl);
    @(posedge ref_clk_in);
    if (rise) rise_event_in <= 1'b1;
    else fall_event_in <= 1'b1;
    repeat (20) @(negedge ref_clk_in) chk(primary_out, lvl);
    @(posedge ref_clk_in);
    rise_event_in <= 1'b0;
    fall_event_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 5'(i * 4), 8'hff);
      bus(1'b0, 5'(i * 4), 8'h00);
      chk(q, 32'h3f);
    end
    bus(1'b0, 5'h01, 8'h00);
    chk(q, 32'h0);
    $display("test registers done");
    bus(1'b1, RISING_DEADBAND_OFS, 8'h02);
    bus(1'b1, FALLING_DEADBAND_OFS, 8'h04);
    bus(1'b1, RISING_BLANKING_OFS, 8'h00);
    bus(1'b1, FALLING_BLANKING_OFS, 8'h00);
    bus(1'b1, RISING_PHASE_OFS, 8'h00);
    bus(1'b1, FALLING_PHASE_OFS, 8'h03);
    bus(1'b1, TIMING_CONTROL_OFS, 8'h01);
    ev(1'b1);
    chk(n_on, 7);
    bus(1'b0, TIMING_STATUS_OFS, 8'h00);
    chk(q, 32'h01);
    ev(1'b0);
    chk(n_off, 7);
    chk(n_on, 12);
    bus(1'b1, RISING_PHASE_OFS, 8'h05);
    ev(1'b1);
    chk(n_off, 9);
    chk(n_on, 12);
    // Chain ticks every other clock; the tick phase moves turn-on by one clock
    bus(1'b1, TIMING_CONTROL_OFS, 8'h41);
    ev(1'b0);
    chk(n_on >= 15 && n_on <= 16, 1);
    bus(1'b1, TIMING_CONTROL_OFS, 8'h81);
    ev(1'b1);
    chk(n_on >= 13 && n_on <= 14, 1);
    $display("test timing done");
    bus(1'b1, FALLING_BLANKING_OFS, 8'h14);
    ev(1'b0);
    hold(1'b1, 1'b0);
    bus(1'b1, FALLING_BLANKING_OFS, 8'h00);
    bus(1'b1, RISING_BLANKING_OFS, 8'h14);
    ev(1'b1);
    bus(1'b0, TIMING_STATUS_OFS, 8'h00);
    chk(q, 32'h05);
    hold(1'b0, 1'b1);
    $display("test blanking done");
    bus(1'b1, FALLING_DEADBAND_OFS, 8'h15);
    rst;
    chk({primary_out, complementary_out}, 2'b00);
    bus(1'b0, FALLING_DEADBAND_OFS, 8'h00);
    chk(q, 32'h15);
    bus(1'b0, TIMING_CONTROL_OFS, 8'h00);
    chk(q, 32'h0);
    chk(overlap, 1'b0);
    $display("test reset done");
    conclude;
  end

  // Whole run needs about 300 clocks; cut a hang well beyond that
  initial begin
    #200000;
    errors++;
    conclude;
  end
endmodule

// [verif/power_stage_model.sv]
// Purpose: Load model of the power-stage drivers on the two waveform outputs.
// Assumes: A high level on either input turns that driver on.
// Notes:   Flags shoot-through; the flag stays set until the end of the run.
`timescale 1ns/1ps
module power_stage_model (
  input  wire logic ref_clk_in,  // Generator clock
  input  wire logic high_in,     // Primary driver gate
  input  wire logic low_in,      // Complementary driver gate
  output logic      overlap_out  // Both drivers were seen on together
);
  // ==========================================================================
  // Shoot-through watch
  // ==========================================================================
  initial overlap_out = 1'b0;
  // Dead-band must keep both gates apart, or the bridge shorts the supply
  always @(posedge ref_clk_in) begin
    if (high_in === 1'b1 && low_in === 1'b1) begin
      overlap_out <= 1'b1;
    end
  end
endmodule
